// File: pkg/rfsc_pkg.sv
// Purpose: Shared constants for the synthesiser clock control block
// Assumes: 8-bit registers, one per aligned 32-bit word on AXI4-Lite
// Notes: Byte address of a register is four times its index
package rfsc_pkg;
  // Register indices
  localparam logic [5:0] IDX_GCON = 6'h00;
  localparam logic [5:0] IDX_FDEV = 6'h02;
  localparam logic [5:0] IDX_BRS = 6'h03;
  localparam logic [5:0] IDX_R1 = 6'h06;
  localparam logic [5:0] IDX_P1 = 6'h07;
  localparam logic [5:0] IDX_S1 = 6'h08;
  localparam logic [5:0] IDX_R2 = 6'h09;
  localparam logic [5:0] IDX_P2 = 6'h0a;
  localparam logic [5:0] IDX_S2 = 6'h0b;
  localparam logic [5:0] IDX_FTPRI = 6'h0e;
  localparam logic [5:0] IDX_HOST_REF_CLOCK_OUT = 6'h1b;
  localparam logic [5:0] IDX_MODCTL = 6'h20;

  // Reset values
  localparam logic [7:0] RST_GCON = 8'h20;
  localparam logic [7:0] RST_FDEV = 8'h03;
  localparam logic [7:0] RST_BRS = 8'h07;
  localparam logic [7:0] RST_R1 = 8'h77;
  localparam logic [7:0] RST_P1 = 8'h64;
  localparam logic [7:0] RST_S1 = 8'h32;
  localparam logic [7:0] RST_R2 = 8'h74;
  localparam logic [7:0] RST_P2 = 8'h62;
  localparam logic [7:0] RST_S2 = 8'h32;
  localparam logic [7:0] RST_FTPRI = 8'h01;
  localparam logic [7:0] RST_HOST_REF_CLOCK_OUT = 8'hbc;
  localparam logic [7:0] RST_MODCTL = 8'h00;

  // Field positions
  localparam int GCON_MODE_LSB = 5;
  localparam int GCON_BAND_LSB = 3;
  localparam int GCON_TRIM_LSB = 1;
  localparam int GCON_SET_BIT = 0;
  localparam int FTPRI_LOCK_BIT = 1;
  localparam int FTPRI_LPIN_BIT = 0;
  localparam int HOST_REF_CLOCK_OUT_EN_BIT = 7;
  localparam int HOST_REF_CLOCK_OUT_SEL_LSB = 2;
  localparam int MODCTL_OOK_BIT = 0;

  // Divisor scales
  localparam int BR_SCALE = 64;
  localparam int DEV_SCALE = 32;
  localparam logic [15:0] LO_P_SCALE = 16'h004b;

  typedef enum logic [2:0] {
    MODE_SLEEP = 3'b000,
    MODE_STANDBY = 3'b001,
    MODE_SYNTH = 3'b010,
    MODE_RX = 3'b011,
    MODE_TX = 3'b100
  } rfsc_mode_t;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: pkg/rfsc_rate_if.sv
// Purpose: Enable, divisor and output between control and rate logic
// Assumes: One clock domain
// Notes: tick is a pulse for rate generators, a level for clock out
`timescale 1ns/1ps
interface rfsc_rate_if #(parameter int DIV_W = 8);
  logic en;
  logic [DIV_W-1:0] div;
  logic tick;
  modport ctrl (output en, output div, input tick);
  modport gen (input en, input div, output tick);
endinterface

// File: src/rfsc_rate_gen.sv
// Purpose: One-cycle tick every SCALE*(div+1) clock cycles
// Assumes: div stable while enabled; changes take effect next period
// Notes: Counter held at zero while disabled so the first tick is prompt
`timescale 1ns/1ps
module rfsc_rate_gen #(
  parameter int SCALE = 64,
  parameter int CNT_W = 14
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Rate control
  rfsc_rate_if.gen rif
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] period_m1;

  always_comb begin
    period_m1 = CNT_W'(SCALE) * (CNT_W'(rif.div) + CNT_W'(1))
      - CNT_W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !rif.en) begin
      cnt <= '0;
      rif.tick <= 1'b0;
    end else if (cnt == '0) begin
      cnt <= period_m1;
      rif.tick <= 1'b1;
    end else begin
      cnt <= cnt - CNT_W'(1);
      rif.tick <= 1'b0;
    end
  end
endmodule

// File: src/rfsc_clkdiv.sv
// Purpose: Square wave at f/(2*(div+1)) for the host clock pin
// Assumes: aclk stands for the crystal reference
// Notes: Output parks low while disabled, no runt on enable
`timescale 1ns/1ps
module rfsc_clkdiv #(
  parameter int SEL_W = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Divider control
  rfsc_rate_if.gen rif
);
  logic [SEL_W-1:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn || !rif.en) begin
      cnt <= '0;
      rif.tick <= 1'b0;
    end else if (cnt >= rif.div) begin
      cnt <= '0;
      rif.tick <= ~rif.tick;
    end else begin
      cnt <= cnt + SEL_W'(1);
    end
  end
endmodule

// File: src/rfsc_top.sv
// Purpose: Register file and digital control of synthesis and clocking
// Assumes: pll_lock_in synchronous to aclk; aclk is the crystal rate
// Notes: 8-bit registers sit in the low byte of each AXI word
`timescale 1ns/1ps
module rfsc_top
  import rfsc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Synthesiser status
  input wire logic pll_lock_in,
  // Pins and synthesiser settings
  output logic host_ref_clock_out,
  output logic lock_indicator_pin,
  output logic tx_bit_clock,
  output logic dev_step_tick,
  output logic tx_mode_active,
  output logic sleep_active,
  output logic [1:0] vco_band_sel,
  output logic [1:0] vco_trim_field,
  output logic [8:0] synth_ref_div,
  output logic [15:0] synth_lo_mult,
  output logic [7:0] deviation_divisor_field,
  output logic carrier_ook_offset
);
  // Registers
  logic [7:0] general_config_register;
  logic [7:0] deviation_register;
  logic [7:0] bitrate_register;
  logic [7:0] div_r1, div_p1, div_s1;
  logic [7:0] div_r2, div_p2, div_s2;
  logic [7:0] pll_irq_config_register;
  logic [7:0] clock_output_control_register;
  logic [7:0] mod_ctl;
  logic pll_lock_sticky_flag;
  logic lock_prev;

  // Bus state
  logic aw_hold, w_hold;
  logic [5:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic do_write;
  logic wr_hit;
  logic [7:0] rd_byte;
  logic rd_hit;

  // Decoded fields
  logic [2:0] operating_mode_field;
  logic host_ref_clock_out_pin_enable;
  logic [4:0] host_ref_clock_out_divider_sel;
  logic lock_pin_enable;
  logic [6:0] bitrate_divisor_field;
  logic set_sel;
  logic [7:0] sel_r, sel_p, sel_s;

  assign operating_mode_field =
    general_config_register[GCON_MODE_LSB +: 3];
  assign host_ref_clock_out_pin_enable =
    clock_output_control_register[HOST_REF_CLOCK_OUT_EN_BIT];
  assign host_ref_clock_out_divider_sel =
    clock_output_control_register[HOST_REF_CLOCK_OUT_SEL_LSB +: 5];
  assign lock_pin_enable = pll_irq_config_register[FTPRI_LPIN_BIT];
  assign bitrate_divisor_field = bitrate_register[6:0];
  assign set_sel = general_config_register[GCON_SET_BIT];

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;
  assign do_write = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_idx <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_idx <= s_axi_awaddr[7:2];
    end else if (do_write) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_hold <= 1'b0;
    end
  end

  always_comb begin
    unique case (aw_idx)
      IDX_GCON, IDX_FDEV, IDX_BRS, IDX_R1, IDX_P1, IDX_S1,
      IDX_R2, IDX_P2, IDX_S2, IDX_FTPRI, IDX_HOST_REF_CLOCK_OUT,
      IDX_MODCTL: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      general_config_register <= RST_GCON;
      deviation_register <= RST_FDEV;
      bitrate_register <= RST_BRS;
      div_r1 <= RST_R1;
      div_p1 <= RST_P1;
      div_s1 <= RST_S1;
      div_r2 <= RST_R2;
      div_p2 <= RST_P2;
      div_s2 <= RST_S2;
      pll_irq_config_register <= RST_FTPRI;
      clock_output_control_register <= RST_HOST_REF_CLOCK_OUT;
      mod_ctl <= RST_MODCTL;
    end else if (do_write && w_lane0) begin
      unique case (aw_idx)
        IDX_GCON: general_config_register <= w_byte;
        IDX_FDEV: deviation_register <= w_byte;
        IDX_BRS: bitrate_register <= {1'b0, w_byte[6:0]};
        IDX_R1: div_r1 <= w_byte;
        IDX_P1: div_p1 <= w_byte;
        IDX_S1: div_s1 <= w_byte;
        IDX_R2: div_r2 <= w_byte;
        IDX_P2: div_p2 <= w_byte;
        IDX_S2: div_s2 <= w_byte;
        IDX_FTPRI: pll_irq_config_register <= w_byte;
        IDX_HOST_REF_CLOCK_OUT: clock_output_control_register <= {w_byte[7:2], 2'b00};
        IDX_MODCTL: mod_ctl <= {7'h00, w_byte[MODCTL_OOK_BIT]};
        default: ;
      endcase
    end
  end

  // Sticky lock flag: a new lock outranks a clearing write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_prev <= 1'b0;
      pll_lock_sticky_flag <= 1'b0;
    end else begin
      lock_prev <= pll_lock_in;
      if (pll_lock_in && !lock_prev)
        pll_lock_sticky_flag <= 1'b1;
      else if (do_write && w_lane0 && aw_idx == IDX_FTPRI &&
               w_byte[FTPRI_LOCK_BIT])
        pll_lock_sticky_flag <= 1'b0;
    end
  end

  // Read channel
  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr[7:2])
      IDX_GCON: rd_byte = general_config_register;
      IDX_FDEV: rd_byte = deviation_register;
      IDX_BRS: rd_byte = bitrate_register;
      IDX_R1: rd_byte = div_r1;
      IDX_P1: rd_byte = div_p1;
      IDX_S1: rd_byte = div_s1;
      IDX_R2: rd_byte = div_r2;
      IDX_P2: rd_byte = div_p2;
      IDX_S2: rd_byte = div_s2;
      IDX_FTPRI: rd_byte = {pll_irq_config_register[7:2],
                            pll_lock_sticky_flag,
                            pll_irq_config_register[0]};
      IDX_HOST_REF_CLOCK_OUT: rd_byte = clock_output_control_register;
      IDX_MODCTL: rd_byte = mod_ctl;
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Rate and clock generators
  rfsc_rate_if #(.DIV_W(5)) ck_if ();
  rfsc_rate_if #(.DIV_W(7)) br_if ();
  rfsc_rate_if #(.DIV_W(8)) dv_if ();

  // Sleep stops the host clock whatever the enable bit says
  assign ck_if.en = host_ref_clock_out_pin_enable &&
    (operating_mode_field != MODE_SLEEP);
  assign ck_if.div = host_ref_clock_out_divider_sel;
  assign br_if.en = tx_mode_active;
  assign br_if.div = bitrate_divisor_field;
  assign dv_if.en = operating_mode_field != MODE_SLEEP;
  assign dv_if.div = deviation_register;

  rfsc_clkdiv #(.SEL_W(5)) u_clkdiv (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(ck_if)
  );

  rfsc_rate_gen #(.SCALE(BR_SCALE), .CNT_W(14)) u_bitrate (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(br_if)
  );

  rfsc_rate_gen #(.SCALE(DEV_SCALE), .CNT_W(14)) u_dev (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(dv_if)
  );

  assign host_ref_clock_out = ck_if.tick;
  assign tx_bit_clock = br_if.tick;
  assign dev_step_tick = dv_if.tick;

  // Divider set selection
  always_comb begin
    if (set_sel) begin
      sel_r = div_r2;
      sel_p = div_p2;
      sel_s = div_s2;
    end else begin
      sel_r = div_r1;
      sel_p = div_p1;
      sel_s = div_s1;
    end
  end

  // Synthesiser settings registered so switching sets is glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synth_ref_div <= 9'h000;
      synth_lo_mult <= 16'h0000;
      tx_mode_active <= 1'b0;
      sleep_active <= 1'b0;
      carrier_ook_offset <= 1'b0;
      lock_indicator_pin <= 1'b0;
      vco_band_sel <= 2'b00;
      vco_trim_field <= 2'b00;
      deviation_divisor_field <= 8'h00;
    end else begin
      synth_ref_div <= {1'b0, sel_r} + 9'h001;
      synth_lo_mult <= LO_P_SCALE * ({8'h00, sel_p} + 16'h0001)
        + {8'h00, sel_s};
      tx_mode_active <= operating_mode_field == MODE_TX;
      sleep_active <= operating_mode_field == MODE_SLEEP;
      carrier_ook_offset <= mod_ctl[MODCTL_OOK_BIT] &&
        operating_mode_field == MODE_TX;
      lock_indicator_pin <= lock_pin_enable &&
        pll_lock_sticky_flag;
      vco_band_sel <= general_config_register[GCON_BAND_LSB +: 2];
      vco_trim_field <= general_config_register[GCON_TRIM_LSB +: 2];
      deviation_divisor_field <= deviation_register;
    end
  end
endmodule

// File: verif/rfsc_chk.sv
// Purpose: Bus and pin timing checks on rfsc_top
// Assumes: One clock, synchronous active-low reset
// Notes: Rate checks test multiples, so divisor writes are harmless
`timescale 1ns/1ps
module rfsc_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins
  input wire logic host_ref_clock_out,
  input wire logic lock_indicator_pin,
  input wire logic tx_bit_clock,
  input wire logic dev_step_tick,
  input wire logic tx_mode_active,
  input wire logic sleep_active,
  input wire logic carrier_ook_offset
);
  logic [13:0] tgap;
  logic [13:0] dgap;
  logic tseen;
  logic dseen;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn || !tx_mode_active) begin
      tgap <= '0;
      tseen <= 1'h0;
    end else begin
      tgap <= tx_bit_clock ? '0 : tgap + 14'h1;
      tseen <= tseen | tx_bit_clock;
    end
  end
  // Sleep restarts the count, since the first tick after it is prompt
  always_ff @(posedge aclk) begin
    if (!aresetn || sleep_active) begin
      dgap <= '0;
      dseen <= 1'h0;
    end else begin
      dgap <= dev_step_tick ? '0 : dgap + 14'h1;
      dseen <= dseen | dev_step_tick;
    end
  end
  chk_clk_sleep: assert property (
    sleep_active [*2] |-> !host_ref_clock_out)
    else $error("clock pin runs in sleep");
  chk_pin_clear: assert property (
    $fell(lock_indicator_pin) |-> $past(s_axi_bvalid))
    else $error("lock pin fell without a write");
  chk_tx_only: assert property (
    tx_bit_clock |-> tx_mode_active || $past(tx_mode_active))
    else $error("bit clock outside transmit");
  chk_bit_pulse: assert property (
    tx_bit_clock |=> !tx_bit_clock [*8])
    else $error("bit clock pulse too long");
  chk_bit_rate: assert property (
    tseen && tx_bit_clock |-> tgap[5:0] == 6'h3f)
    else $error("bit period not a multiple of 64");
  chk_dev_rate: assert property (
    dseen && dev_step_tick |-> dgap[4:0] == 5'h1f)
    else $error("deviation period not a multiple of 32");
  chk_ook_tx: assert property (
    carrier_ook_offset |-> tx_mode_active)
    else $error("offset outside transmit");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  cover property (tseen && tx_bit_clock);
  cover property ($fell(lock_indicator_pin));
  cover property (sleep_active [*2]);
  cover property (carrier_ook_offset);
endmodule

bind rfsc_top rfsc_chk u_chk (.*);

// File: verif/rfsc_host.sv
// Purpose: Host controller model on the register bus
// Assumes: Called just after a rising edge
// Notes: Start and ready delays vary to exercise stalls
`timescale 1ns/1ps
module rfsc_host (
  // Clock
  input wire logic aclk,
  // Write side
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // Read side
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Drives every bus output low at time zero so the bus starts idle
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb,
     s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot, s_axi_arvalid,
     s_axi_rready} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    logic ga;
    logic gw;
    ga = 1'h0;
    gw = 1'h0;
    repeat ($urandom % 2) @(posedge aclk);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (!ga && s_axi_awready) begin
        ga = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!gw && s_axi_wready) begin
        gw = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q,
                    output logic [1:0] r);
    repeat ($urandom % 2) @(posedge aclk);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    repeat ($urandom % 3) @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
endmodule

// File: verif/test_rf_synth_clock_control.sv
// Purpose: Self-checking bench for the synthesiser clock control
// Assumes: Host model on the bus, lock input driven here
// Notes: Small divisors keep the rate checks short
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %0h got %0h", n, e, a); end end
module test_rf_synth_clock_control;
  import rfsc_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic pll_lock_in = 1'h0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, deviation_divisor_field;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, host_ref_clock_out, tx_bit_clock;
  logic lock_indicator_pin, dev_step_tick, tx_mode_active;
  logic sleep_active, carrier_ook_offset;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, vco_band_sel, vco_trim_field, rs;
  logic [8:0] synth_ref_div;
  logic [15:0] synth_lo_mult;
  logic [5:0] b;
  int num_errors = 0;
  int n_checks = 0;
  int mdl [int];
  int n, rr, pp, ss;
  logic [5:0] ix [12] = '{IDX_GCON, IDX_FDEV, IDX_BRS, IDX_R1, IDX_P1,
    IDX_S1, IDX_R2, IDX_P2, IDX_S2, IDX_FTPRI, IDX_HOST_REF_CLOCK_OUT, IDX_MODCTL};
  logic [7:0] rv [12] = '{RST_GCON, RST_FDEV, RST_BRS, RST_R1, RST_P1,
    RST_S1, RST_R2, RST_P2, RST_S2, RST_FTPRI, RST_HOST_REF_CLOCK_OUT, RST_MODCTL};
  always #2.5 aclk = ~aclk;
  rfsc_top u_dut (.*);
  rfsc_host u_host (.*);
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic w(input logic [5:0] i, input logic [7:0] d);
    u_host.wr({i, 2'h0}, d, 4'h1, rs);
    mdl[i] = d;
    `CHK("bresp", RESP_OKAY, rs)
  endtask
  task automatic r(input logic [5:0] i);
    u_host.rd({i, 2'h0}, q, rs);
    `CHK("rdata", mdl[i], q)
  endtask
  function automatic logic sg(input int k);
    case (k)
      0: return host_ref_clock_out;
      1: return tx_bit_clock;
      default: return dev_step_tick;
    endcase
  endfunction
  // Cycles between two rising edges of the chosen output
  task automatic gap(input int k, output int g);
    int t0;
    logic p;
    t0 = -1;
    g = -1;
    p = 1'h1;
    for (int c = 0; c < 6000 && g < 0; c++) begin
      @(posedge aclk);
      if (sg(k) && !p) begin
        if (t0 >= 0) g = c - t0;
        t0 = c;
      end
      p = sg(k);
    end
  endtask
  task automatic quiet(output int h);
    h = 0;
    repeat (3) @(posedge aclk);
    repeat (40) begin
      @(posedge aclk);
      h += int'(host_ref_clock_out !== 1'h0);
    end
  endtask
  initial begin
    repeat (50000) @(posedge aclk);
    num_errors++;
    conclude();
  end
  initial begin
    n = $urandom(32'h5083);
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (ix[k]) mdl[ix[k]] = rv[k];
    foreach (ix[k]) r(ix[k]);
    gap(0, n);
    `CHK("clk period", 32, n)
    for (int s = 0; s < 2; s++) begin
      rr = s ? 64 + $urandom % 106 : 119;
      pp = $urandom % 256;
      ss = $urandom % (pp + 1);
      b = s ? IDX_R2 : IDX_R1;
      w(b, 8'(rr));
      w(b + 6'h1, 8'(pp));
      w(b + 6'h2, 8'(ss));
      w(IDX_GCON, {3'h1, s ? 2'h1 : 2'h2, 2'(s), 1'(s)});
      r(b + 6'h2);
      `CHK("ref div", rr + 1, synth_ref_div)
      `CHK("lo mult", 75 * (pp + 1) + ss, synth_lo_mult)
      `CHK("vco", {s ? 2'h1 : 2'h2, 2'(s)}, {vco_band_sel, vco_trim_field})
    end
    rr = $urandom % 32;
    w(IDX_HOST_REF_CLOCK_OUT, {1'h1, 5'(rr), 2'h0});
    gap(0, n);
    gap(0, n);
    `CHK("clk period", 2 * (rr + 1), n)
    w(IDX_HOST_REF_CLOCK_OUT, 8'h7c);
    quiet(n);
    `CHK("clk off", 0, n)
    w(IDX_HOST_REF_CLOCK_OUT, 8'hbc);
    pll_lock_in <= 1'h1;
    mdl[IDX_FTPRI] = 8'h03;
    r(IDX_FTPRI);
    `CHK("lock pin", 1'h1, lock_indicator_pin)
    w(IDX_FTPRI, 8'h01);
    mdl[IDX_FTPRI] = 8'h03;
    r(IDX_FTPRI);
    w(IDX_FTPRI, 8'h03);
    mdl[IDX_FTPRI] = 8'h01;
    r(IDX_FTPRI);
    `CHK("lock pin", 1'h0, lock_indicator_pin)
    pll_lock_in <= 1'h0;
    w(IDX_BRS, 8'($urandom % 4));
    w(IDX_FDEV, 8'($urandom % 8));
    // Lock edge lands on the same cycle as the clearing write
    fork
      w(IDX_FTPRI, 8'h03);
      begin
        do @(posedge aclk); while (!(s_axi_awvalid && s_axi_awready));
        pll_lock_in <= 1'h1;
      end
    join
    r(IDX_FTPRI);
    `CHK("lock pin", 1'h1, lock_indicator_pin)
    pll_lock_in <= 1'h0;
    w(IDX_GCON, 8'h80);
    // Mode outputs are registered one edge after the write lands
    @(posedge aclk);
    `CHK("tx mode", 1'h1, tx_mode_active)
    gap(1, n);
    `CHK("bit period", 64 * (mdl[IDX_BRS] + 1), n)
    gap(2, n);
    `CHK("dev period", 32 * (mdl[IDX_FDEV] + 1), n)
    w(IDX_MODCTL, 8'h01);
    @(posedge aclk);
    `CHK("ook", 1'h1, carrier_ook_offset)
    `CHK("dev field", mdl[IDX_FDEV], deviation_divisor_field)
    // Receive keeps the OOK offset off; its placement is up to software
    w(IDX_GCON, 8'h60);
    @(posedge aclk);
    `CHK("ook rx", 1'h0, carrier_ook_offset)
    `CHK("rx not tx", 1'h0, tx_mode_active)
    w(IDX_GCON, 8'h00);
    quiet(n);
    `CHK("sleep clk", 0, n)
    `CHK("sleep", 1'h1, sleep_active)
    u_host.rd(8'h04, q, rs);
    `CHK("rresp", RESP_SLVERR, rs)
    u_host.wr(8'h04, 8'hff, 4'h1, rs);
    `CHK("bresp", RESP_SLVERR, rs)
    u_host.wr({IDX_FDEV, 2'h0}, 8'h55, 4'h0, rs);
    `CHK("bresp", RESP_OKAY, rs)
    r(IDX_FDEV);
    conclude();
  end
endmodule
